/* core/osa_averager.sv */
// First-slot offset subtraction and power-of-two sample averager, AHB-Lite
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ns
module osa_averager
  import osa_pkg::*;
#(
  parameter int RAW_W = 16
) (
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET_N,
  // AHB-Lite slave
  input  wire logic              HSEL,
  input  wire logic [31:0]       HADDR,
  input  wire logic [1:0]        HTRANS,
  input  wire logic              HWRITE,
  input  wire logic [2:0]        HSIZE,
  input  wire logic [31:0]       HWDATA,
  input  wire logic              HREADY,
  output logic [31:0]            HRDATA,
  output logic                   HREADYOUT,
  output logic                   HRESP,
  // Raw conversions, one per channel
  input  wire logic              SAMPLE_VALID,
  output logic                   SAMPLE_READY,
  input  wire logic [1:0]        SAMPLE_CHAN,
  input  wire logic [RAW_W-1:0]  SAMPLE_DATA,
  // Averaged results, channel in top two bits
  output logic                   RESULT_VALID,
  input  wire logic              RESULT_READY,
  output logic [FIFO_W-1:0]      RESULT_DATA,
  // Second slot code for the neighbouring slot
  output logic [2:0]             SECOND_SLOT_CODE
);
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // Number of samples in a group for a code
  function automatic logic [7:0] group_size(input logic [2:0] code);
    group_size = 8'h01 << code;
  endfunction : group_size

  // Signed offset-corrected sample, sign extended to the sum width
  function automatic logic signed [SUM_W-1:0] corrected(
    input logic [RAW_W-1:0] raw,
    input logic [15:0]      off
  );
    corrected = SUM_W'($signed({1'b0, raw}) - $signed({1'b0, off}));
  endfunction : corrected

  // ---------------------------------------------------------------------------
  // Register bus
  // ---------------------------------------------------------------------------
  logic [2:0]  first_code_reg, first_code_next;
  logic [2:0]  second_code_reg, second_code_next;
  logic [15:0] off_reg [4];
  logic [15:0] off_next [4];
  logic        overflow_reg, overflow_next;
  logic        wr_pend_reg, wr_pend_next;
  logic [7:0]  wr_idx_reg, wr_idx_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [5:0]  fifo_level;
  logic        drop_evt;
  logic        addr_phase;
  logic [7:0]  a_idx;

  // Address phase decode; writes land one cycle later with HWDATA
  always_comb begin
    addr_phase       = HSEL && HREADY && HTRANS[1];
    a_idx            = HADDR[9:2];
    wr_pend_next     = addr_phase && HWRITE;
    wr_idx_next      = addr_phase ? a_idx : wr_idx_reg;
    first_code_next  = first_code_reg;
    second_code_next = second_code_reg;
    for (int i = 0; i < 4; i++) begin
      off_next[i] = off_reg[i];
    end
    if (wr_pend_reg) begin
      case (wr_idx_reg)
        IDX_AVG_CONFIG: begin
          first_code_next  = HWDATA[FIRST_CODE_LSB +: 3];
          second_code_next = HWDATA[SECOND_CODE_LSB +: 3];
        end
        IDX_CHAN1_OFFSET: off_next[0] = HWDATA[15:0];
        IDX_CHAN2_OFFSET: off_next[1] = HWDATA[15:0];
        IDX_CHAN3_OFFSET: off_next[2] = HWDATA[15:0];
        IDX_CHAN4_OFFSET: off_next[3] = HWDATA[15:0];
        default: ;
      endcase
    end
    // Set wins over a clear by write in the same cycle
    overflow_next = drop_evt ||
      (overflow_reg && !(wr_pend_reg && wr_idx_reg == IDX_STATUS
                         && HWDATA[8]));
    // Read data registered at the address phase; unmapped reads give zero
    rdata_next = rdata_reg;
    if (addr_phase && !HWRITE) begin
      case (a_idx)
        IDX_AVG_CONFIG: rdata_next = {21'h0, second_code_reg, 1'b0,
                                      first_code_reg, 4'h0};
        IDX_CHAN1_OFFSET: rdata_next = {16'h0, off_reg[0]};
        IDX_CHAN2_OFFSET: rdata_next = {16'h0, off_reg[1]};
        IDX_CHAN3_OFFSET: rdata_next = {16'h0, off_reg[2]};
        IDX_CHAN4_OFFSET: rdata_next = {16'h0, off_reg[3]};
        IDX_STATUS: rdata_next = {23'h0, overflow_reg, 2'h0, fifo_level};
        default: rdata_next = 32'h0;
      endcase
    end
  end

  // Bus registers; reset restores documented defaults
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      first_code_reg  <= FIRST_CODE_RST;
      second_code_reg <= SECOND_CODE_RST;
      for (int i = 0; i < 4; i++) begin
        off_reg[i] <= OFFSET_RST;
      end
      overflow_reg <= 1'b0;
      wr_pend_reg  <= 1'b0;
      wr_idx_reg   <= 8'h0;
      rdata_reg    <= 32'h0;
    end else begin
      first_code_reg  <= first_code_next;
      second_code_reg <= second_code_next;
      for (int i = 0; i < 4; i++) begin
        off_reg[i] <= off_next[i];
      end
      overflow_reg <= overflow_next;
      wr_pend_reg  <= wr_pend_next;
      wr_idx_reg   <= wr_idx_next;
      rdata_reg    <= rdata_next;
    end
  end

  assign HRDATA           = rdata_reg;
  assign HREADYOUT        = 1'b1;
  assign HRESP            = 1'b0;
  assign SECOND_SLOT_CODE = second_code_reg;

  // ---------------------------------------------------------------------------
  // Accumulator datapath
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SUM  = 2'b01,
    ST_EMIT = 2'b10
  } osa_state_t;

  osa_state_t                state_reg, state_next;
  logic signed [SUM_W-1:0]   sum_reg [4];
  logic signed [SUM_W-1:0]   sum_next [4];
  logic [7:0]                cnt_reg [4];
  logic [7:0]                cnt_next [4];
  logic [1:0]                emit_ch_reg, emit_ch_next;
  logic [2:0]                emit_code_reg, emit_code_next;
  logic signed [SUM_W-1:0]   add_val;
  logic signed [SUM_W-1:0]   avg_val;
  logic                      push_valid, push_ready;
  logic [FIFO_W-1:0]         push_data;

  // A sample is taken only while the accumulator is not waiting on the FIFO
  always_comb begin
    state_next     = state_reg;
    emit_ch_next   = emit_ch_reg;
    emit_code_next = emit_code_reg;
    for (int i = 0; i < 4; i++) begin
      sum_next[i] = sum_reg[i];
      cnt_next[i] = cnt_reg[i];
    end
    SAMPLE_READY = 1'b0;
    push_valid   = 1'b0;
    add_val      = corrected(SAMPLE_DATA, off_reg[SAMPLE_CHAN]);
    // Arithmetic shift divides the group sum by its size
    avg_val      = sum_reg[emit_ch_reg] >>> emit_code_reg;
    push_data    = {emit_ch_reg, avg_val[15:0]};
    drop_evt     = 1'b0;
    case (state_reg)
      ST_SUM: begin
        SAMPLE_READY = 1'b1;
        if (SAMPLE_VALID) begin
          // Code 0 closes the group at the first sample
          sum_next[SAMPLE_CHAN] = (cnt_reg[SAMPLE_CHAN] == 8'h0)
                                ? add_val : sum_reg[SAMPLE_CHAN] + add_val;
          cnt_next[SAMPLE_CHAN] = cnt_reg[SAMPLE_CHAN] + 8'h01;
          if (cnt_reg[SAMPLE_CHAN] + 8'h01
              >= group_size(first_code_reg)) begin
            cnt_next[SAMPLE_CHAN] = 8'h0;
            emit_ch_next   = SAMPLE_CHAN;
            emit_code_next = first_code_reg;
            state_next     = ST_EMIT;
          end
        end
      end
      ST_EMIT: begin
        // Holds the result until the FIFO accepts it; source stalls meanwhile
        push_valid = 1'b1;
        if (push_ready) begin
          state_next = ST_SUM;
        end
      end
      default: state_next = ST_SUM;
    endcase
  end

  // Accumulator state
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg     <= ST_SUM;
      emit_ch_reg   <= 2'h0;
      emit_code_reg <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        sum_reg[i] <= '0;
        cnt_reg[i] <= 8'h0;
      end
    end else begin
      state_reg     <= state_next;
      emit_ch_reg   <= emit_ch_next;
      emit_code_reg <= emit_code_next;
      for (int i = 0; i < 4; i++) begin
        sum_reg[i] <= sum_next[i];
        cnt_reg[i] <= cnt_next[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Result FIFO
  // ---------------------------------------------------------------------------
  osa_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .CLK       (CLK),
    .RESET_N   (RESET_N),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   (push_data),
    .out_valid (RESULT_VALID),
    .out_ready (RESULT_READY),
    .out_data  (RESULT_DATA),
    .level     (fifo_level)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  chk_code_reset: assert property (@(posedge CLK)
    $rose(RESET_N) |-> first_code_reg == 3'h0 && second_code_reg == 3'h6)
    else $error("slot codes not at reset values");
  chk_code_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr_pend_reg && wr_idx_reg == IDX_AVG_CONFIG
      |=> first_code_reg == $past(HWDATA[6:4]))
    else $error("first slot code not written");
  chk_second_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr_pend_reg && wr_idx_reg == IDX_AVG_CONFIG
      |=> SECOND_SLOT_CODE == $past(HWDATA[10:8]))
    else $error("second slot code not written");
  chk_group_close: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_reg == ST_SUM && SAMPLE_VALID
      && cnt_reg[SAMPLE_CHAN] == group_size(first_code_reg) - 8'h01
      |=> state_reg == ST_EMIT)
    else $error("group did not close at its size");
  chk_single_sample: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_reg == ST_SUM && SAMPLE_VALID && first_code_reg == 3'h0
      |=> state_reg == ST_EMIT && avg_val == $past(add_val))
    else $error("code zero must pass one sample");
  chk_no_early_emit: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_reg == ST_SUM && SAMPLE_VALID
      && cnt_reg[SAMPLE_CHAN] + 8'h02 <= group_size(first_code_reg)
      |=> state_reg == ST_SUM)
    else $error("result before group complete");
  chk_off1_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr_pend_reg && wr_idx_reg == IDX_CHAN1_OFFSET
      |=> off_reg[0] == $past(HWDATA[15:0]))
    else $error("channel 1 offset not written");
  chk_off2_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr_pend_reg && wr_idx_reg == IDX_CHAN2_OFFSET
      |=> off_reg[1] == $past(HWDATA[15:0]))
    else $error("channel 2 offset not written");
  chk_off3_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr_pend_reg && wr_idx_reg == IDX_CHAN3_OFFSET
      |=> off_reg[2] == $past(HWDATA[15:0]))
    else $error("channel 3 offset not written");
  chk_off4_write: assert property (@(posedge CLK) disable iff (!RESET_N)
    wr_pend_reg && wr_idx_reg == IDX_CHAN4_OFFSET
      |=> off_reg[3] == $past(HWDATA[15:0]))
    else $error("channel 4 offset not written");
  // Floor division: the remainder left by the average lies below the factor
  chk_avg_shift: assert property (@(posedge CLK) disable iff (!RESET_N)
    state_reg == ST_EMIT
      |-> $unsigned(sum_reg[emit_ch_reg] - (avg_val <<< emit_code_reg))
            < {16'h0, group_size(emit_code_reg)})
    else $error("average is not sum over factor");
endmodule : osa_averager

/* core/osa_fifo.sv */
// Synchronous FIFO with valid/ready on both sides, registered read data
`timescale 1ns/1ns
module osa_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             CLK,
  input  wire logic             RESET_N,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  // Occupancy
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg, wr_next, rd_reg, rd_next;
  logic [WIDTH-1:0] dout_reg, dout_next;
  logic             dv_reg, dv_next;
  logic             push, pop_mem, stored_empty;

  // Output register counts as one stage ahead of the array
  always_comb begin
    stored_empty = (wr_reg == rd_reg);
    in_ready     = ((wr_reg - rd_reg) != (AW+1)'(DEPTH));
    push         = in_valid && in_ready;
    pop_mem      = !stored_empty && (!dv_reg || out_ready);
    wr_next      = push ? wr_reg + 1'b1 : wr_reg;
    rd_next      = pop_mem ? rd_reg + 1'b1 : rd_reg;
    dout_next    = pop_mem ? mem[rd_reg[AW-1:0]] : dout_reg;
    dv_next      = pop_mem ? 1'b1 : (out_ready ? 1'b0 : dv_reg);
    out_valid    = dv_reg;
    out_data     = dout_reg;
    level        = wr_reg - rd_reg;
  end

  // Array write has no reset, so it is kept out of the reset process
  always_ff @(posedge CLK) begin
    if (push) begin
      mem[wr_reg[AW-1:0]] <= in_data;
    end
  end

  // Pointer and output registers
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_reg   <= '0;
      rd_reg   <= '0;
      dout_reg <= '0;
      dv_reg   <= 1'b0;
    end else begin
      wr_reg   <= wr_next;
      rd_reg   <= rd_next;
      dout_reg <= dout_next;
      dv_reg   <= dv_next;
    end
  end
endmodule : osa_fifo

/* core/osa_pkg.sv */
// Package: register map, field layout, reset values and widths of the averager
package osa_pkg;
  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_AVG_CONFIG   = 8'h15;
  localparam logic [7:0]  IDX_CHAN1_OFFSET = 8'h18;
  localparam logic [7:0]  IDX_CHAN2_OFFSET = 8'h19;
  localparam logic [7:0]  IDX_CHAN3_OFFSET = 8'h1a;
  localparam logic [7:0]  IDX_CHAN4_OFFSET = 8'h1b;
  // Status register of own choice: FIFO level and overflow
  localparam logic [7:0]  IDX_STATUS       = 8'h30;
  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int          FIRST_CODE_LSB   = 4;
  localparam int          SECOND_CODE_LSB  = 8;
  localparam logic [2:0]  FIRST_CODE_RST   = 3'h0;
  localparam logic [2:0]  SECOND_CODE_RST  = 3'h6;
  localparam logic [15:0] OFFSET_RST       = 16'h2000;
  localparam int          MAX_CODE         = 7;
  localparam int          SUM_W            = 24;
  localparam int          FIFO_W           = 18;
  localparam int          FIFO_D           = 32;
endpackage : osa_pkg

/* verif/osa_averager_bench.sv */
// Self-checking bench for the offset-subtracting sample averager
`timescale 1ns/1ns
module osa_averager_bench;
  import osa_pkg::*;
  // ---------------------------------------------------------------------------
  // Clock, reset and design ports
  // ---------------------------------------------------------------------------
  logic        clk          = 1'b0;
  logic        reset_n      = 1'b0;
  logic        hsel         = 1'b1;
  logic [31:0] haddr        = 32'h0;
  logic [1:0]  htrans       = 2'h0;
  logic        hwrite       = 1'b0;
  logic [2:0]  hsize        = 3'h2;
  logic [31:0] hwdata       = 32'h0;
  logic        sample_valid = 1'b0;
  logic [1:0]  sample_chan  = 2'h0;
  logic [15:0] sample_data  = 16'h0;
  logic        result_ready = 1'b1;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        sample_ready;
  logic        result_valid;
  logic [17:0] result_data;
  logic [2:0]  second_slot_code;
  int          mismatches   = 0;
  int          total_checks = 0;
  logic [17:0] exp_q[$];
  logic [15:0] offs[4]      = '{16'h1f00, 16'h1f40, 16'h1f80, 16'h1fc0};

  // Period of 50 ns for the 20 MHz sample clock
  always #25 clk = ~clk;

  osa_averager dut_u (
    .CLK              (clk),
    .RESET_N          (reset_n),
    .HSEL             (hsel),
    .HADDR            (haddr),
    .HTRANS           (htrans),
    .HWRITE           (hwrite),
    .HSIZE            (hsize),
    .HWDATA           (hwdata),
    .HREADY           (hreadyout),
    .HRDATA           (hrdata),
    .HREADYOUT        (hreadyout),
    .HRESP            (hresp),
    .SAMPLE_VALID     (sample_valid),
    .SAMPLE_READY     (sample_ready),
    .SAMPLE_CHAN      (sample_chan),
    .SAMPLE_DATA      (sample_data),
    .RESULT_VALID     (result_valid),
    .RESULT_READY     (result_ready),
    .RESULT_DATA      (result_data),
    .SECOND_SLOT_CODE (second_slot_code)
  );

  // ---------------------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  // ---------------------------------------------------------------------------
  // AHB-Lite single word transfers, entered just after a rising edge
  // ---------------------------------------------------------------------------
  task automatic bus(input logic [7:0] idx, input logic wr,
                     input logic [31:0] wdata, output logic [31:0] rdata);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 100);
    htrans <= 2'h0;
    hwdata <= wdata;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 200);
    rdata = hrdata;
    // A wait that runs out is a failure, not a silent carry-on
    if (hreadyout !== 1'b1) begin
      mismatches++;
    end
  endtask : bus

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp,
                    input string name);
    logic [31:0] r;
    bus(idx, 1'b0, 32'h0, r);
    check(name, r, exp);
    check("bus response", {31'h0, hresp}, 32'h0);
  endtask : rd

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(idx, 1'b1, d, r);
  endtask : wr

  // ---------------------------------------------------------------------------
  // Sample stream: valid held until taken; ok is low on a refusal
  // ---------------------------------------------------------------------------
  task automatic send(input logic [1:0] ch, input logic [15:0] raw,
                      input int limit, output bit ok);
    int n;
    n = 0;
    sample_valid <= 1'b1;
    sample_chan  <= ch;
    sample_data  <= raw;
    do begin @(posedge clk); n++; end while (sample_ready !== 1'b1 && n < limit);
    // Taken only if ready stood at the last edge waited for
    ok = (sample_ready === 1'b1);
  endtask : send

  // One full group on one channel; expected average queued at its close
  task automatic group(input int code, input logic [1:0] ch);
    int sum;
    int avg;
    bit ok;
    sum = 0;
    for (int k = 0; k < (1 << code); k++) begin
      send(ch, offs[ch] + 16'(k * 7 - 300), 1000, ok);
      sum += k * 7 - 300;
      if (!ok) begin
        mismatches++;
      end
    end
    // Drop valid so the last sample is not taken a second time later
    sample_valid <= 1'b0;
    avg = sum >>> code;
    exp_q.push_back({ch, avg[15:0]});
  endtask : group

  // Every result popped against the queue; a surplus one is flagged
  always @(posedge clk) begin
    if (reset_n && result_valid === 1'b1 && result_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("surplus result", 32'h1, 32'h0);
      end else begin
        check("result", {14'h0, result_data}, {14'h0, exp_q.pop_front()});
      end
    end
  end

  // Watchdog well beyond the expected run of several hundred cycles
  initial begin
    #(50 * 40000);
    mismatches++;
    stop_test();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    bit ok;
    int n;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // Reset defaults of the register map and the second slot pin
    check("second code pin", {29'h0, second_slot_code}, 32'h6);
    rd(IDX_AVG_CONFIG, 32'h0000_0600, "config reset");
    rd(IDX_CHAN1_OFFSET, 32'h2000, "chan1 offset reset");
    rd(IDX_CHAN2_OFFSET, 32'h2000, "chan2 offset reset");
    rd(IDX_CHAN3_OFFSET, 32'h2000, "chan3 offset reset");
    rd(IDX_CHAN4_OFFSET, 32'h2000, "chan4 offset reset");
    // Unmapped place ignores writes and reads zero
    wr(8'h40, 32'hffff_ffff);
    rd(8'h40, 32'h0, "unmapped read");
    // Only the two code fields survive a write of ones to the low 16 bits
    wr(IDX_AVG_CONFIG, 32'h0000_ffff);
    rd(IDX_AVG_CONFIG, 32'h0000_0770, "config fields");
    check("second code pin", {29'h0, second_slot_code}, 32'h7);
    // Distinct offsets so a swapped channel shows in the results
    for (int c = 0; c < 4; c++) begin
      wr(IDX_CHAN1_OFFSET + 8'(c), {16'h0, offs[c]});
      rd(IDX_CHAN1_OFFSET + 8'(c), {16'h0, offs[c]}, "offset");
    end
    // Every averaging code, on channels 0 to 3 in turn (code modulo 4)
    for (int code = 0; code <= MAX_CODE; code++) begin
      wr(IDX_AVG_CONFIG, 32'h0000_0600 | (32'(code) << 4));
      group(code, 2'(code % 4));
    end
    // Two channels interleaved at code 1 keep separate groups
    wr(IDX_AVG_CONFIG, 32'h0000_0610);
    send(2'h0, offs[0] + 16'h10, 1000, ok);
    send(2'h1, offs[1] - 16'h20, 1000, ok);
    send(2'h0, offs[0] + 16'h30, 1000, ok);
    exp_q.push_back({2'h0, 16'h0020});
    send(2'h1, offs[1] - 16'h40, 1000, ok);
    exp_q.push_back({2'h1, 16'hffd0});
    sample_valid <= 1'b0;
    repeat (20) @(posedge clk);
    check("queue empty", 32'(exp_q.size()), 32'h0);
    // Fill the result FIFO with the drain stalled until samples are refused
    result_ready <= 1'b0;
    wr(IDX_AVG_CONFIG, 32'h0000_0600);
    for (int i = 0; i < 40; i++) begin
      send(2'h0, offs[0] + 16'(i), 50, ok);
      exp_q.push_back({2'h0, 16'(i)});
      if (!ok) break;
    end
    rd(IDX_STATUS, 32'h20, "fifo level full");
    check("sample ready when full", {31'h0, sample_ready}, 32'h0);
    // Release the drain; the held sample is taken once space frees
    result_ready <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (sample_ready !== 1'b1 && n < 200);
    if (sample_ready !== 1'b1) begin
      mismatches++;
    end
    sample_valid <= 1'b0;
    repeat (100) @(posedge clk);
    check("queue drained", 32'(exp_q.size()), 32'h0);
    check("result valid idle", {31'h0, result_valid}, 32'h0);
    rd(IDX_STATUS, 32'h0, "fifo level empty");
    stop_test();
  end
endmodule : osa_averager_bench
